// File: idm_top.sv
`timescale 1ns/1ns
`include "idm_defs.svh"
module idm_top
    import idm_pkg::*;
#(
    parameter int          CNT_W       = 26,
    parameter int          PER_W       = 20,
    parameter int unsigned SAT_CYCLES  =
        `IDM_SAT_MS * (`IDM_CLK_HZ / `IDM_MS_PER_S),
    parameter int unsigned HOLD_CYCLES =
        `IDM_HOLD_MS * (`IDM_CLK_HZ / `IDM_MS_PER_S),
    parameter logic [6:0]  STATUS_ADDR = 7'h01,
    parameter logic [6:0]  BEAT_ADDR   = 7'h25
)
(
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Serial port pins.
    input  wire logic               sclk,
    input  wire logic               csb_n,
    input  wire logic               sdi,
    output logic                    sdo,
    output logic                    sdo_oe,
    // Datapath events and levels.
    input  wire logic               sample_tick,
    input  wire logic               rwave_detect,
    input  wire logic signed [17:0] ecg_out,
    input  wire logic [5:0]         fifo_count,
    // Interrupt enables from the enable register.
    input  wire logic               en_fifo_irq,
    input  wire logic               en_recovery_irq,
    input  wire logic               en_rwave_irq,
    input  wire logic               en_sample_pulse,
    // Interrupt terms and outputs.
    output logic                    fifo_threshold_irq,
    output logic                    recovery_irq,
    output logic                    rwave_irq,
    output logic                    sample_pulse,
    output logic                    irq_n,
    output logic                    hpf_bypass,
    output logic                    soft_reset_out
);

    localparam logic [CNT_W-1:0] SAT_LIM  = CNT_W'(SAT_CYCLES);
    localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_CYCLES - 1);

    function automatic logic hit(input logic done, input logic rd,
                                 input logic [6:0] a, input logic [6:0] t,
                                 input logic want_rd);
        hit = done && (rd == want_rd) && (a == t);
    endfunction

    function automatic logic [3:0] rate_mask(input logic [1:0] code);
        case (code)
            2'h0:    rate_mask = 4'h0;
            2'h1:    rate_mask = 4'h1;
            2'h2:    rate_mask = 4'h3;
            default: rate_mask = 4'hF;
        endcase
    endfunction

    logic [2:0]  lvl;
    logic [6:0]  cmd_addr;
    logic        cmd_read;
    logic        hdr_done;
    logic [23:0] wr_data;
    logic        frame_done;
    logic [23:0] rd_data;
    logic        rd_own;

    idm_pin_sync #(.W(3)) u_sync
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .pin_in  ({sdi, csb_n, sclk}),
        .rst_val (3'h2),
        .lvl_out (lvl)
    );

    idm_spi_slave u_spi
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .sclk_lvl   (lvl[0]),
        .csb_n_lvl  (lvl[1]),
        .sdi_lvl    (lvl[2]),
        .rd_data    (rd_data),
        .rd_own     (rd_own),
        .cmd_addr   (cmd_addr),
        .cmd_read   (cmd_read),
        .hdr_done   (hdr_done),
        .wr_data    (wr_data),
        .frame_done (frame_done),
        .sdo        (sdo),
        .sdo_oe     (sdo_oe)
    );

    // Configuration registers.
    logic [4:0] fit_reg,   fit_next;
    logic       rclr_reg,  rclr_next;
    logic [1:0] rwclr_reg, rwclr_next;
    logic       sclr_reg,  sclr_next;
    logic [1:0] rate_reg,  rate_next;
    logic [1:0] mode_reg,  mode_next;
    logic [5:0] th_reg,    th_next;
    logic       swrst_reg, swrst_next;
    logic       wr_int, wr_dyn, rd_status, rd_beat;

    assign wr_int    = hit(frame_done, cmd_read, cmd_addr, `IDM_ADDR_INT, 1'b0);
    assign wr_dyn    = hit(frame_done, cmd_read, cmd_addr, `IDM_ADDR_DYN, 1'b0);
    assign rd_status = hit(frame_done, cmd_read, cmd_addr, STATUS_ADDR, 1'b1);
    assign rd_beat   = hit(frame_done, cmd_read, cmd_addr, BEAT_ADDR, 1'b1);

    // Fields not listed never store and read back as zero.
    always_comb
    begin
        rd_data = '0;
        rd_own  = 1'b0;
        if (cmd_addr == `IDM_ADDR_INT)
        begin
            rd_own = 1'b1;
            rd_data[`IDM_FIT_HI:`IDM_FIT_LO]     = fit_reg;
            rd_data[`IDM_RCLR_BIT]               = rclr_reg;
            rd_data[`IDM_RWCLR_HI:`IDM_RWCLR_LO] = rwclr_reg;
            rd_data[`IDM_SCLR_BIT]               = sclr_reg;
            rd_data[`IDM_RATE_HI:`IDM_RATE_LO]   = rate_reg;
        end
        else if (cmd_addr == `IDM_ADDR_DYN)
        begin
            rd_own = 1'b1;
            rd_data[`IDM_MODE_HI:`IDM_MODE_LO] = mode_reg;
            rd_data[`IDM_TH_HI:`IDM_TH_LO]     = th_reg;
        end
    end

    always_comb
    begin
        fit_next   = fit_reg;
        rclr_next  = rclr_reg;
        rwclr_next = rwclr_reg;
        sclr_next  = sclr_reg;
        rate_next  = rate_reg;
        mode_next  = mode_reg;
        th_next    = th_reg;
        swrst_next = hit(frame_done, cmd_read, cmd_addr, `IDM_ADDR_SWRST,
                         1'b0) && (wr_data == `IDM_DATA_ZERO);
        if (wr_int)
        begin
            fit_next   = wr_data[`IDM_FIT_HI:`IDM_FIT_LO];
            rclr_next  = wr_data[`IDM_RCLR_BIT];
            rwclr_next = wr_data[`IDM_RWCLR_HI:`IDM_RWCLR_LO];
            sclr_next  = wr_data[`IDM_SCLR_BIT];
            rate_next  = wr_data[`IDM_RATE_HI:`IDM_RATE_LO];
        end
        // No resync or FIFO flush follows a mode change.
        if (wr_dyn)
        begin
            mode_next = wr_data[`IDM_MODE_HI:`IDM_MODE_LO];
            th_next   = wr_data[`IDM_TH_HI:`IDM_TH_LO];
        end
        if (swrst_reg)
        begin
            fit_next   = `IDM_FIT_RST;
            rclr_next  = `IDM_RCLR_RST;
            rwclr_next = `IDM_RWCLR_RST;
            sclr_next  = `IDM_SCLR_RST;
            rate_next  = `IDM_RATE_RST;
            mode_next  = `IDM_MODE_RST;
            th_next    = `IDM_TH_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fit_reg   <= `IDM_FIT_RST;
            rclr_reg  <= `IDM_RCLR_RST;
            rwclr_reg <= `IDM_RWCLR_RST;
            sclr_reg  <= `IDM_SCLR_RST;
            rate_reg  <= `IDM_RATE_RST;
            mode_reg  <= `IDM_MODE_RST;
            th_reg    <= `IDM_TH_RST;
            swrst_reg <= 1'b0;
        end
        else
        begin
            fit_reg   <= fit_next;
            rclr_reg  <= rclr_next;
            rwclr_reg <= rwclr_next;
            sclr_reg  <= sclr_next;
            rate_reg  <= rate_next;
            mode_reg  <= mode_next;
            th_reg    <= th_next;
            swrst_reg <= swrst_next;
        end
    end

    // Fast recovery engine.
    idm_ar_e          ar_reg,  ar_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [17:0]      th_pos;
    logic             saturated;
    logic             auto_mode;
    logic             active_next;

    assign th_pos    = 18'(th_reg) << `IDM_TH_SHIFT;
    assign saturated = (ecg_out > $signed(th_pos))
                    || (ecg_out < -$signed(th_pos));
    assign auto_mode = (mode_reg == IDM_FAST_AUTO);

    always_comb
    begin
        ar_next  = ar_reg;
        cnt_next = cnt_reg;
        case (ar_reg)
            IDM_AR_IDLE:
            begin
                cnt_next = '0;
                if (auto_mode && saturated)
                begin
                    ar_next = IDM_AR_WATCH;
                end
            end
            IDM_AR_WATCH:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (!auto_mode || !saturated)
                begin
                    ar_next = IDM_AR_IDLE;
                end
                else if (cnt_reg == SAT_LIM)
                begin
                    ar_next  = IDM_AR_HOLD;
                    cnt_next = '0;
                end
            end
            IDM_AR_HOLD:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (!auto_mode || cnt_reg == HOLD_LIM)
                begin
                    ar_next = IDM_AR_IDLE;
                end
            end
            default:
            begin
                ar_next = IDM_AR_IDLE;
            end
        endcase
        if (swrst_reg)
        begin
            ar_next  = IDM_AR_IDLE;
            cnt_next = '0;
        end
        // Reserved code three acts as normal mode.
        case (mode_next)
            IDM_FAST_MANUAL: active_next = 1'b1;
            IDM_FAST_AUTO:   active_next = (ar_next == IDM_AR_HOLD);
            default:         active_next = 1'b0;
        endcase
        if (swrst_reg)
        begin
            active_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ar_reg     <= IDM_AR_IDLE;
            cnt_reg    <= '0;
            hpf_bypass <= 1'b0;
        end
        else
        begin
            ar_reg     <= ar_next;
            cnt_reg    <= cnt_next;
            hpf_bypass <= active_next;
        end
    end

    // Sample period measurement, divider and interrupt terms.
    logic [PER_W-1:0] per_cnt_reg, per_cnt_next;
    logic [PER_W-1:0] period_reg,  period_next;
    logic [PER_W-1:0] age_reg,     age_next;
    logic [PER_W-1:0] quarter;
    logic [3:0]       div_reg,     div_next;
    logic             rw_armed_reg, rw_armed_next;
    logic             fifo_next, rec_next, rw_next, sample_pulse_next;
    logic             rec_rise;

    assign quarter  = (period_reg >> 2) == '0 ? PER_W'(1) : period_reg >> 2;
    assign rec_rise = active_next && !hpf_bypass;

    always_comb
    begin
        per_cnt_next = (&per_cnt_reg) ? per_cnt_reg : per_cnt_reg + 1'b1;
        period_next  = period_reg;
        div_next     = div_reg;
        age_next     = sample_pulse ? age_reg + 1'b1 : '0;
        sample_pulse_next    = sample_pulse;
        if (sample_pulse && sclr_reg && (age_reg + 1'b1 >= quarter))
        begin
            sample_pulse_next = 1'b0;
        end
        if (sample_pulse && !sclr_reg && rd_status)
        begin
            sample_pulse_next = 1'b0;
        end
        if (sample_tick)
        begin
            period_next  = per_cnt_reg + 1'b1;
            per_cnt_next = '0;
            div_next     = div_reg + 4'h1;
            if ((div_reg & rate_mask(rate_reg)) == 4'h0)
            begin
                sample_pulse_next = 1'b1;
                age_next  = '0;
            end
        end
        // Threshold plus one, compared in six bits to cover 32.
        fifo_next = fifo_count >= ({1'b0, fit_reg} + 6'h01);
        rec_next  = recovery_irq;
        if (rd_status && (rclr_reg || !active_next))
        begin
            rec_next = 1'b0;
        end
        if (rec_rise || (!rclr_reg && active_next))
        begin
            rec_next = 1'b1;
        end
        rw_next       = rwave_irq;
        rw_armed_next = rw_armed_reg;
        case (rwclr_reg)
            IDM_RW_ON_BEAT: if (rd_beat) rw_next = 1'b0;
            IDM_RW_SELF:
            begin
                if (sample_tick && rw_armed_reg)
                begin
                    rw_next = 1'b0;
                end
            end
            default: if (rd_status) rw_next = 1'b0;
        endcase
        if (sample_tick)
        begin
            rw_armed_next = rwave_irq;
        end
        if (rwave_detect)
        begin
            rw_next       = 1'b1;
            rw_armed_next = 1'b0;
        end
        if (swrst_reg)
        begin
            per_cnt_next  = '0;
            period_next   = '0;
            div_next      = '0;
            age_next      = '0;
            sample_pulse_next     = 1'b0;
            fifo_next     = 1'b0;
            rec_next      = 1'b0;
            rw_next       = 1'b0;
            rw_armed_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            per_cnt_reg        <= '0;
            period_reg         <= '0;
            age_reg            <= '0;
            div_reg            <= '0;
            rw_armed_reg       <= 1'b0;
            fifo_threshold_irq <= 1'b0;
            recovery_irq       <= 1'b0;
            rwave_irq          <= 1'b0;
            sample_pulse       <= 1'b0;
            irq_n              <= 1'b1;
            soft_reset_out     <= 1'b0;
        end
        else
        begin
            per_cnt_reg        <= per_cnt_next;
            period_reg         <= period_next;
            age_reg            <= age_next;
            div_reg            <= div_next;
            rw_armed_reg       <= rw_armed_next;
            fifo_threshold_irq <= fifo_next;
            recovery_irq       <= rec_next;
            rwave_irq          <= rw_next;
            sample_pulse       <= sample_pulse_next;
            irq_n              <= ~((en_fifo_irq && fifo_next)
                               || (en_recovery_irq && rec_next)
                               || (en_rwave_irq && rw_next)
                               || (en_sample_pulse && sample_pulse_next));
            soft_reset_out     <= swrst_reg;
        end
    end

endmodule

// File: idm_defs.svh
`ifndef IDM_DEFS_SVH
`define IDM_DEFS_SVH

// Register addresses on the serial port.
`define IDM_ADDR_INT      7'h04
`define IDM_ADDR_DYN      7'h05
`define IDM_ADDR_SWRST    7'h08

// Interrupt manager fields.
`define IDM_FIT_HI        23
`define IDM_FIT_LO        19
`define IDM_RCLR_BIT      6
`define IDM_RWCLR_HI      5
`define IDM_RWCLR_LO      4
`define IDM_SCLR_BIT      2
`define IDM_RATE_HI       1
`define IDM_RATE_LO       0

// Dynamic mode fields.
`define IDM_MODE_HI       23
`define IDM_MODE_LO       22
`define IDM_TH_HI         21
`define IDM_TH_LO         16

// Reset values.
`define IDM_FIT_RST       5'h0F
`define IDM_RCLR_RST      1'h0
`define IDM_RWCLR_RST     2'h0
`define IDM_SCLR_RST      1'h1
`define IDM_RATE_RST      2'h0
`define IDM_MODE_RST      2'h0
`define IDM_TH_RST        6'h3F

// Threshold scale is 2048, a left shift by eleven.
`define IDM_TH_SHIFT      11

// Serial frame shape.
`define IDM_HDR_LAST      6'h07
`define IDM_FRAME_LAST    6'h1F
`define IDM_DATA_ZERO     24'h000000

// Timing.
`define IDM_CLK_HZ        100000000
`define IDM_SAT_MS        125
`define IDM_HOLD_MS       500
`define IDM_MS_PER_S      1000

`endif

// File: idm_pkg.sv
package idm_pkg;

    typedef enum logic [1:0]
    {
        IDM_FAST_OFF    = 2'h0,
        IDM_FAST_MANUAL = 2'h1,
        IDM_FAST_AUTO   = 2'h2,
        IDM_FAST_RSVD   = 2'h3
    } idm_fast_e;

    typedef enum logic [1:0]
    {
        IDM_RW_ON_STATUS = 2'h0,
        IDM_RW_ON_BEAT   = 2'h1,
        IDM_RW_SELF      = 2'h2,
        IDM_RW_RSVD      = 2'h3
    } idm_rwclr_e;

    // Gray order along idle, watch, hold.
    typedef enum logic [1:0]
    {
        IDM_AR_IDLE  = 2'h0,
        IDM_AR_WATCH = 2'h1,
        IDM_AR_HOLD  = 2'h3
    } idm_ar_e;

endpackage

// File: idm_pin_sync.sv
`timescale 1ns/1ns
module idm_pin_sync
#(
    parameter int W = 3
)
(
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Pins and filtered levels.
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] lvl_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] lvl_next;
    logic [1:0]   init_reg;
    logic [1:0]   init_next;

    always_comb
    begin
        lvl_next  = lvl_out;
        init_next = init_reg;
        for (int i = 0; i < W; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
            begin
                lvl_next[i] = s3_reg[i];
            end
        end
        // Reset leaves zeros in the chain, so the reset level is held until
        // the third flop carries a real pin sample; this avoids a false select.
        if (!(&init_reg))
        begin
            lvl_next  = rst_val;
            init_next = init_reg + 2'h1;
        end
    end

    // The reset value is taken by a clocked load so no port feeds the reset.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            lvl_out  <= '0;
            init_reg <= '0;
        end
        else
        begin
            s1_reg   <= pin_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            lvl_out  <= lvl_next;
            init_reg <= init_next;
        end
    end

endmodule

// File: idm_spi_slave.sv
`timescale 1ns/1ns
`include "idm_defs.svh"
module idm_spi_slave
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Filtered serial levels.
    input  wire logic        sclk_lvl,
    input  wire logic        csb_n_lvl,
    input  wire logic        sdi_lvl,
    // Read data from the register file.
    input  wire logic [23:0] rd_data,
    input  wire logic        rd_own,
    // Decoded frame.
    output logic      [6:0]  cmd_addr,
    output logic             cmd_read,
    output logic             hdr_done,
    output logic      [23:0] wr_data,
    output logic             frame_done,
    // Serial out.
    output logic             sdo,
    output logic             sdo_oe
);

    logic        sclk_q_reg;
    logic [5:0]  cnt_reg;
    logic [5:0]  cnt_next;
    logic [31:0] in_reg;
    logic [31:0] in_next;
    logic [23:0] out_reg;
    logic [23:0] out_next;
    logic [6:0]  addr_next;
    logic        read_next;
    logic        hdr_next;
    logic [23:0] wr_next;
    logic        done_next;
    logic        sdo_next;
    logic        oe_next;
    logic        rise;
    logic        fall;

    assign rise = sclk_lvl & ~sclk_q_reg;
    assign fall = ~sclk_lvl & sclk_q_reg;

    always_comb
    begin
        cnt_next  = cnt_reg;
        in_next   = in_reg;
        out_next  = out_reg;
        addr_next = cmd_addr;
        read_next = cmd_read;
        hdr_next  = 1'b0;
        wr_next   = wr_data;
        done_next = 1'b0;
        sdo_next  = sdo;
        oe_next   = sdo_oe;
        if (csb_n_lvl)
        begin
            cnt_next = '0;
            oe_next  = 1'b0;
        end
        else
        begin
            if (rise)
            begin
                in_next  = {in_reg[30:0], sdi_lvl};
                cnt_next = cnt_reg + 6'h01;
                if (cnt_reg == `IDM_HDR_LAST)
                begin
                    addr_next = in_reg[6:0];
                    read_next = sdi_lvl;
                    hdr_next  = 1'b1;
                end
                if (cnt_reg == `IDM_FRAME_LAST)
                begin
                    wr_next   = {in_reg[22:0], sdi_lvl};
                    done_next = 1'b1;
                    cnt_next  = '0;
                end
            end
            // Only registers of this block are driven; other units answer
            // for their own addresses.
            if (hdr_done && cmd_read && rd_own)
            begin
                out_next = rd_data;
                oe_next  = 1'b1;
            end
            else if (fall && sdo_oe)
            begin
                sdo_next = out_reg[23];
                out_next = {out_reg[22:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q_reg <= 1'b0;
            cnt_reg    <= '0;
            in_reg     <= '0;
            out_reg    <= '0;
            cmd_addr   <= '0;
            cmd_read   <= 1'b0;
            hdr_done   <= 1'b0;
            wr_data    <= '0;
            frame_done <= 1'b0;
            sdo        <= 1'b0;
            sdo_oe     <= 1'b0;
        end
        else
        begin
            sclk_q_reg <= sclk_lvl;
            cnt_reg    <= cnt_next;
            in_reg     <= in_next;
            out_reg    <= out_next;
            cmd_addr   <= addr_next;
            cmd_read   <= read_next;
            hdr_done   <= hdr_next;
            wr_data    <= wr_next;
            frame_done <= done_next;
            sdo        <= sdo_next;
            sdo_oe     <= oe_next;
        end
    end

endmodule

// File: idm_top_checker.sv
`timescale 1ns/1ns
module idm_top_checker
(
    // Clock, reset and inputs.
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sample_tick,
    input wire logic       rwave_detect,
    input wire logic [5:0] fifo_count,
    input wire logic       en_fifo_irq,
    input wire logic       en_recovery_irq,
    input wire logic       en_rwave_irq,
    input wire logic       en_sample_pulse,
    // Outputs.
    input wire logic       fifo_threshold_irq,
    input wire logic       recovery_irq,
    input wire logic       rwave_irq,
    input wire logic       sample_pulse,
    input wire logic       irq_n,
    input wire logic       hpf_bypass,
    input wire logic       soft_reset_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_or;
        irq_n == !(|({fifo_threshold_irq, recovery_irq, rwave_irq,
            sample_pulse} & $past({en_fifo_irq, en_recovery_irq,
            en_rwave_irq, en_sample_pulse})));
    endproperty
    a_or: assert property (p_or) else $error("irq_n wrong");
    property p_sp;
        $rose(sample_pulse) |-> $past(sample_tick);
    endproperty
    a_sp: assert property (p_sp) else $error("pulse without tick");
    property p_rw;
        $rose(rwave_irq) |-> $past(rwave_detect);
    endproperty
    a_rw: assert property (p_rw) else $error("rwave without detect");
    property p_rc;
        $rose(recovery_irq) |-> hpf_bypass || $past(hpf_bypass);
    endproperty
    a_rc: assert property (p_rc) else $error("stray rec irq");
    property p_sr;
        soft_reset_out |=> !soft_reset_out;
    endproperty
    a_sr: assert property (p_sr) else $error("reset pulse long");
    property p_sd;
        soft_reset_out |-> !hpf_bypass && !rwave_irq;
    endproperty
    a_sd: assert property (p_sd) else $error("state kept");
    property p_f0;
        fifo_count == 6'h00 |=> !fifo_threshold_irq;
    endproperty
    a_f0: assert property (p_f0) else $error("fifo irq at zero");
    property p_fr;
        $rose(fifo_threshold_irq) |-> $past(fifo_count) != 6'h00;
    endproperty
    a_fr: assert property (p_fr) else $error("fifo irq early");
endmodule
bind idm_top idm_top_checker u_chk (.*);

// File: idm_host.sv
`timescale 1ns/1ns
module idm_host
(
    // Serial pins.
    output logic      sclk,
    output logic      csb_n,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    initial
    begin
        sclk = 0;
        csb_n = 1;
        sdi = 0;
    end
    // Samples late in the high phase since sdo lags the falling edge.
    task xfer(input logic [6:0] a, input logic rd, input logic [23:0] d,
              output logic [23:0] q);
        logic [31:0] f;
        f = {a, rd, d};
        csb_n = 0;
        #40;
        for (int i = 31; i >= 0; i--)
        begin
            sdi = f[i];
            #40 sclk = 1;
            // An undriven line reads as the inverse, so a lost enable shows.
            #39 q = {q[22:0], sdo_oe ? sdo : ~sdo};
            #1 sclk = 0;
        end
        sdi = ~sdi;
        #40 csb_n = 1;
        #200;
    endtask
endmodule

// File: tb_interrupt_and_dynamic_mode_regs.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module tb_interrupt_and_dynamic_mode_regs;
    logic clk, rst_n, sclk, csb_n, sdi, sdo, sdo_oe, sample_tick;
    logic rwave_detect, en_fifo_irq, en_recovery_irq, en_rwave_irq;
    logic en_sample_pulse, fifo_threshold_irq, recovery_irq, rwave_irq;
    logic sample_pulse, irq_n, hpf_bypass, soft_reset_out, sp_q;
    logic signed [17:0] ecg_out;
    logic [5:0]         fifo_count;
    logic [23:0]        q;
    int n_fail, cmp_count, n_sp, n_sr;
    idm_top #(.SAT_CYCLES(50), .HOLD_CYCLES(200)) u_dut (.*);
    idm_host u_host (.*);
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (sample_pulse && !sp_q) n_sp++;
        if (soft_reset_out) n_sr++;
        sp_q <= sample_pulse;
    end
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task tk(int n);
        repeat (n)
        begin
            @(negedge clk) sample_tick = 1;
            @(negedge clk) sample_tick = 0;
            repeat (6) @(negedge clk);
        end
    endtask
    task rw_pulse;
        @(negedge clk) rwave_detect = 1;
        @(negedge clk) rwave_detect = 0;
        @(negedge clk) `CHK(rwave_irq, 1'b1)
    endtask
    task wait_bypass;
        repeat (80) if (!hpf_bypass) @(negedge clk);
    endtask
    initial
    begin
        #900000 n_fail++;
        end_of_test;
    end
    initial
    begin
        {sample_tick, rwave_detect, ecg_out, fifo_count, rst_n} = 0;
        {en_fifo_irq, en_recovery_irq, en_rwave_irq, en_sample_pulse} = 4'hF;
        repeat (16) @(negedge clk);
        rst_n = 1;
        repeat (8) @(negedge clk);
        u_host.xfer(7'h04, 1, 0, q); `CHK(q, 24'h780004)
        u_host.xfer(7'h05, 1, 0, q); `CHK(q, 24'h3F0000)
        u_host.xfer(7'h04, 0, 24'hFFFFE7, q);
        u_host.xfer(7'h04, 1, 0, q); `CHK(q, 24'hF80067)
        fifo_count = 31;
        repeat (3) @(negedge clk); `CHK(fifo_threshold_irq, 1'b0)
        fifo_count = 32;
        repeat (3) @(negedge clk); `CHK(irq_n, 1'b0)
        `CHK(fifo_threshold_irq, 1'b1)
        fifo_count = 0;
        n_sp = 0;
        tk(32); `CHK(n_sp, 2)
        rw_pulse;
        tk(2); `CHK(rwave_irq, 1'b0)
        $display("irq tests done");
        u_host.xfer(7'h08, 0, 24'h000001, q); `CHK(n_sr, 0)
        u_host.xfer(7'h04, 1, 0, q); `CHK(q, 24'hF80067)
        u_host.xfer(7'h08, 0, 24'h000000, q); `CHK(n_sr, 1)
        u_host.xfer(7'h04, 1, 0, q); `CHK(q, 24'h780004)
        rw_pulse;
        tk(2); `CHK(rwave_irq, 1'b1)
        u_host.xfer(7'h01, 1, 0, q); `CHK(rwave_irq, 1'b0)
        $display("reset tests done");
        u_host.xfer(7'h05, 0, 24'h400000, q); `CHK(hpf_bypass, 1'b1)
        ecg_out = 2048;
        u_host.xfer(7'h05, 0, 24'h810000, q);
        repeat (70) @(negedge clk); `CHK(hpf_bypass, 1'b0)
        ecg_out = 2049;
        wait_bypass; `CHK(hpf_bypass, 1'b1)
        ecg_out = 0;
        repeat (150) @(negedge clk); `CHK(hpf_bypass, 1'b1)
        repeat (60) @(negedge clk); `CHK(hpf_bypass, 1'b0)
        `CHK(recovery_irq, 1'b1)
        u_host.xfer(7'h01, 1, 0, q); `CHK(recovery_irq, 1'b0)
        $display("recovery tests done");
        u_host.xfer(7'h04, 0, 24'h780050, q);
        u_host.xfer(7'h05, 0, 24'h400000, q);
        rw_pulse;
        tk(1); `CHK(sample_pulse, 1'b1)
        u_host.xfer(7'h01, 1, 0, q); `CHK(recovery_irq, 1'b0)
        `CHK(sample_pulse, 1'b0)
        `CHK(rwave_irq, 1'b1)
        `CHK(hpf_bypass, 1'b1)
        u_host.xfer(7'h25, 1, 0, q); `CHK(rwave_irq, 1'b0)
        u_host.xfer(7'h05, 0, 0, q);
        u_host.xfer(7'h05, 0, 24'h400000, q); `CHK(recovery_irq, 1'b1)
        $display("clear tests done");
        end_of_test;
    end
endmodule
